// ===== logic/bcc_params.svh
`ifndef BCC_PARAMS_SVH
`define BCC_PARAMS_SVH

// Register byte offsets
`define BCC_OFF_POLICY      8'h00
`define BCC_OFF_RES_OHMS    8'h04
`define BCC_OFF_MAX_POWER   8'h08
`define BCC_OFF_DECAY       8'h0C
`define BCC_OFF_INV_MASK    8'h10
`define BCC_OFF_POS_SRC     8'h14
`define BCC_OFF_STATUS      8'h18
`define BCC_OFF_CONTROL     8'h1C

// Reset values
`define BCC_RST_POLICY      16'h0002
`define BCC_RST_RES_OHMS    16'h0000
`define BCC_RST_MAX_POWER   16'h0000
`define BCC_RST_DECAY       16'h0032
`define BCC_RST_INV_MASK    16'h0000
`define BCC_RST_POS_SRC     16'h0000
`define BCC_RST_CONTROL     16'h0000

// Legal maxima
`define BCC_MAX_POLICY      16'h0003
`define BCC_MAX_DECAY       16'h0064
`define BCC_MAX_INV_MASK    16'h0007
`define BCC_MAX_POS_SRC     16'h0006
`define BCC_MAX_MAX_POWER   16'h7FFF

// Field positions
`define BCC_INV_POS_BIT     0
`define BCC_INV_SPD_BIT     1
`define BCC_INV_TRQ_BIT     2
`define BCC_ST_BRAKE_BIT    0
`define BCC_ST_OVF_BIT      1
`define BCC_ST_HOT_BIT      2
`define BCC_ST_OVLIM_BIT    3
`define BCC_CTL_HICLASS_BIT 0

// Braking limits in volts
`define BCC_BRAKE_LIM_LO_V  16'd380
`define BCC_BRAKE_LIM_HI_V  16'd680

// Thermal model timing
`define BCC_CLK_PERIOD_NS   8
`define BCC_TICK_NS         1000000
`define BCC_DECAY_FULL_MS   10000
`define BCC_DECAY_PCT_FULL  100

`endif

// ===== logic/bcc_pkg.sv
package bcc_pkg;

  typedef enum logic [1:0] {
    BCC_POL_NEVER = 2'h0,
    BCC_POL_DECEL = 2'h1,
    BCC_POL_ANY   = 2'h2,
    BCC_POL_REGEN = 2'h3
  } bcc_policy_t;

  typedef enum logic [2:0] {
    BCC_SRC_PULSE   = 3'h0,
    BCC_SRC_PLAN    = 3'h1,
    BCC_SRC_SWITCH  = 3'h2,
    BCC_SRC_ENC2    = 3'h3,
    BCC_SRC_PULSE_P = 3'h4,
    BCC_SRC_LABEL   = 3'h5,
    BCC_SRC_SINE    = 3'h6
  } bcc_src_t;

  typedef logic signed [31:0] bcc_cmd_t;

endpackage

// ===== logic/bcc_heat_model.sv
`timescale 1ns/1ps
`include "bcc_params.svh"

module bcc_heat_model #(
  parameter int TICK_CYC = `BCC_TICK_NS / `BCC_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Model inputs
  input  wire logic        brake_on,
  input  wire logic [15:0] max_power,
  input  wire logic [6:0]  decay_pct,
  // Model outputs
  output logic      [23:0] heat,
  output logic             overheat
);
  import bcc_pkg::*;

  // Heat kept in hundredths so a 1% coefficient still decays each tick
  localparam logic [23:0] HEAT_MAX = 24'(`BCC_DECAY_FULL_MS * `BCC_DECAY_PCT_FULL);

  logic [31:0] tick_cnt_r;
  logic [31:0] tick_cnt_nxt;
  logic [23:0] heat_r;
  logic [23:0] heat_nxt;
  logic [24:0] sum;

  always_comb begin
    tick_cnt_nxt = tick_cnt_r + 32'h00000001;
    heat_nxt     = heat_r;
    sum          = 25'h0000000;
    if (tick_cnt_r >= 32'(TICK_CYC - 1)) begin
      tick_cnt_nxt = 32'h00000000;
      if (brake_on) begin
        sum = {1'b0, heat_r} + {9'h000, max_power};
      end else if (heat_r > {17'h00000, decay_pct}) begin
        sum = {1'b0, heat_r} - {18'h00000, decay_pct};
      end
      // Saturate; full coefficient empties HEAT_MAX in 10 s of 1 ms ticks
      heat_nxt = (sum > {1'b0, HEAT_MAX}) ? HEAT_MAX : sum[23:0];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_r <= 32'h00000000;
      heat_r     <= 24'h000000;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      heat_r     <= heat_nxt;
    end
  end

  assign heat     = heat_r;
  assign overheat = (heat_r == HEAT_MAX);

endmodule

// ===== logic/bcc_top.sv
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "bcc_params.svh"

module bcc_top #(
  parameter logic [15:0] OV_FAULT_LO_V = 16'd420,
  parameter logic [15:0] OV_FAULT_HI_V = 16'd760,
  parameter int          TICK_CYC      = `BCC_TICK_NS / `BCC_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 arst_n,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Bus sensing and motion state
  input  wire logic [15:0]          bus_volt,
  input  wire logic                 decelerating,
  input  wire logic                 regen_active,
  // Input function bits
  input  wire logic                 position_inhibit_in,
  input  wire logic                 position_reverse_in,
  input  wire logic                 position_source_switch_in,
  // Command sources
  input  wire bcc_pkg::bcc_cmd_t    plan_cmd,
  input  wire bcc_pkg::bcc_cmd_t    enc2_cmd,
  input  wire bcc_pkg::bcc_cmd_t    label_cmd,
  input  wire bcc_pkg::bcc_cmd_t    sine_cmd,
  input  wire bcc_pkg::bcc_cmd_t    speed_cmd,
  input  wire bcc_pkg::bcc_cmd_t    torque_cmd,
  // Conditioned commands
  output bcc_pkg::bcc_cmd_t         pos_cmd_out,
  output bcc_pkg::bcc_cmd_t         speed_cmd_out,
  output bcc_pkg::bcc_cmd_t         torque_cmd_out,
  // Power stage
  output logic                      brake_on,
  output logic                      ov_fault,
  output logic                      resistor_overheat
);
  import bcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [15:0] policy_r,    policy_nxt;
  logic [15:0] res_ohms_r,  res_ohms_nxt;
  logic [15:0] max_pwr_r,   max_pwr_nxt;
  logic [15:0] decay_r,     decay_nxt;
  logic [15:0] inv_mask_r,  inv_mask_nxt;
  logic [15:0] pos_src_r,   pos_src_nxt;
  logic [15:0] control_r,   control_nxt;
  logic [31:0] prdata_r,    prdata_nxt;
  logic        pslverr_r,   pslverr_nxt;
  logic        ov_fault_r,  ov_fault_nxt;
  logic        brake_r,     brake_nxt;

  logic        wr_en;
  logic        rd_setup;
  logic        addr_ok;
  logic [15:0] wdat;
  logic [15:0] status;
  logic        ov_clear;
  logic [23:0] heat;
  logic        overheat;

  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign wdat     = pwdata[15:0];

  always_comb begin
    case (paddr)
      `BCC_OFF_POLICY, `BCC_OFF_RES_OHMS, `BCC_OFF_MAX_POWER, `BCC_OFF_DECAY,
      `BCC_OFF_INV_MASK, `BCC_OFF_POS_SRC, `BCC_OFF_STATUS,
      `BCC_OFF_CONTROL: addr_ok = 1'b1;
      default:          addr_ok = 1'b0;
    endcase
  end

  // Out-of-range writes are dropped so settings stay within the legal set
  always_comb begin
    policy_nxt   = policy_r;
    res_ohms_nxt = res_ohms_r;
    max_pwr_nxt  = max_pwr_r;
    decay_nxt    = decay_r;
    inv_mask_nxt = inv_mask_r;
    pos_src_nxt  = pos_src_r;
    control_nxt  = control_r;
    ov_clear     = 1'b0;
    if (wr_en) begin
      case (paddr)
        `BCC_OFF_POLICY: begin
          if (wdat <= `BCC_MAX_POLICY) begin
            policy_nxt = wdat;
          end
        end
        `BCC_OFF_RES_OHMS: begin
          res_ohms_nxt = wdat;
        end
        `BCC_OFF_MAX_POWER: begin
          // Tenths of a kilowatt; codes past the cap would overstate the rating
          if (wdat <= `BCC_MAX_MAX_POWER) begin
            max_pwr_nxt = wdat;
          end
        end
        `BCC_OFF_DECAY: begin
          if (wdat <= `BCC_MAX_DECAY) begin
            decay_nxt = wdat;
          end
        end
        `BCC_OFF_INV_MASK: begin
          if (wdat <= `BCC_MAX_INV_MASK) begin
            inv_mask_nxt = wdat;
          end
        end
        `BCC_OFF_POS_SRC: begin
          if (wdat <= `BCC_MAX_POS_SRC) begin
            pos_src_nxt = wdat;
          end
        end
        `BCC_OFF_STATUS: begin
          ov_clear = wdat[`BCC_ST_OVF_BIT];
        end
        `BCC_OFF_CONTROL: begin
          control_nxt = {15'h0000, wdat[`BCC_CTL_HICLASS_BIT]};
        end
        default: begin
          ov_clear = 1'b0;
        end
      endcase
    end
  end

  // Read data and error captured in the setup cycle; access needs no wait
  always_comb begin
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    if (rd_setup) begin
      pslverr_nxt = ~addr_ok;
      case (paddr)
        `BCC_OFF_POLICY:    prdata_nxt = {16'h0000, policy_r};
        `BCC_OFF_RES_OHMS:  prdata_nxt = {16'h0000, res_ohms_r};
        `BCC_OFF_MAX_POWER: prdata_nxt = {16'h0000, max_pwr_r};
        `BCC_OFF_DECAY:     prdata_nxt = {16'h0000, decay_r};
        `BCC_OFF_INV_MASK:  prdata_nxt = {16'h0000, inv_mask_r};
        `BCC_OFF_POS_SRC:   prdata_nxt = {16'h0000, pos_src_r};
        `BCC_OFF_STATUS:    prdata_nxt = {heat[23:8], status};
        `BCC_OFF_CONTROL:   prdata_nxt = {16'h0000, control_r};
        default:            prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      policy_r   <= `BCC_RST_POLICY;
      res_ohms_r <= `BCC_RST_RES_OHMS;
      max_pwr_r  <= `BCC_RST_MAX_POWER;
      decay_r    <= `BCC_RST_DECAY;
      inv_mask_r <= `BCC_RST_INV_MASK;
      pos_src_r  <= `BCC_RST_POS_SRC;
      control_r  <= `BCC_RST_CONTROL;
      prdata_r   <= 32'h00000000;
      pslverr_r  <= 1'b0;
    end else begin
      policy_r   <= policy_nxt;
      res_ohms_r <= res_ohms_nxt;
      max_pwr_r  <= max_pwr_nxt;
      decay_r    <= decay_nxt;
      inv_mask_r <= inv_mask_nxt;
      pos_src_r  <= pos_src_nxt;
      control_r  <= control_nxt;
      prdata_r   <= prdata_nxt;
      pslverr_r  <= pslverr_nxt;
    end
  end

  assign prdata  = prdata_r;
  // No wait states; every access ends in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Braking decision and overvoltage fault

  logic        hi_class;
  logic [15:0] brake_lim;
  logic [15:0] ov_lim;
  logic        over_lim;
  bcc_policy_t policy;

  assign hi_class  = control_r[`BCC_CTL_HICLASS_BIT];
  assign brake_lim = hi_class ? `BCC_BRAKE_LIM_HI_V : `BCC_BRAKE_LIM_LO_V;
  // Fault threshold sits above the braking limit so braking acts first
  assign ov_lim    = hi_class ? OV_FAULT_HI_V : OV_FAULT_LO_V;
  assign over_lim  = (bus_volt > brake_lim);
  assign policy    = bcc_policy_t'(policy_r[1:0]);

  always_comb begin
    // Re-evaluated every cycle, so the brake drops the cycle after cause ends
    case (policy)
      BCC_POL_NEVER: brake_nxt = 1'b0;
      BCC_POL_DECEL: brake_nxt = over_lim & decelerating;
      BCC_POL_ANY:   brake_nxt = over_lim;
      BCC_POL_REGEN: brake_nxt = over_lim & regen_active;
      default:       brake_nxt = 1'b0;
    endcase
  end

  // Sticky fault; a new overvoltage wins over a clear in the same cycle
  always_comb begin
    ov_fault_nxt = ov_fault_r;
    if (ov_clear) begin
      ov_fault_nxt = 1'b0;
    end
    if (bus_volt > ov_lim) begin
      ov_fault_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      brake_r    <= 1'b0;
      ov_fault_r <= 1'b0;
    end else begin
      brake_r    <= brake_nxt;
      ov_fault_r <= ov_fault_nxt;
    end
  end

  assign brake_on = brake_r;
  assign ov_fault = ov_fault_r;

  // Fed from the registered brake so the model matches the pin exactly
  bcc_heat_model #(
    .TICK_CYC (TICK_CYC)
  ) u_heat (
    .clock     (clock),
    .arst_n    (arst_n),
    .brake_on  (brake_r),
    .max_power (max_pwr_r),
    .decay_pct (decay_r[6:0]),
    .heat      (heat),
    .overheat  (overheat)
  );

  assign resistor_overheat = overheat;

  always_comb begin
    status                      = 16'h0000;
    status[`BCC_ST_BRAKE_BIT]   = brake_r;
    status[`BCC_ST_OVF_BIT]     = ov_fault_r;
    status[`BCC_ST_HOT_BIT]     = overheat;
    status[`BCC_ST_OVLIM_BIT]   = over_lim;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command conditioning

  bcc_cmd_t pos_sel;
  bcc_cmd_t pos_stage;
  bcc_cmd_t pos_nxt,   pos_r;
  bcc_cmd_t spd_nxt,   spd_r;
  bcc_cmd_t trq_nxt,   trq_r;
  bcc_cmd_t pulse_cmd;
  bcc_src_t src;

  // Variant has no pulse input, pulse term is constant zero
  assign pulse_cmd = 32'sh00000000;
  assign src       = bcc_src_t'(pos_src_r[2:0]);

  always_comb begin
    case (src)
      BCC_SRC_PULSE:   pos_sel = pulse_cmd;
      BCC_SRC_PLAN:    pos_sel = plan_cmd;
      BCC_SRC_SWITCH:  pos_sel = position_source_switch_in ? plan_cmd : pulse_cmd;
      BCC_SRC_ENC2:    pos_sel = pulse_cmd + enc2_cmd;
      BCC_SRC_PULSE_P: pos_sel = pulse_cmd + plan_cmd;
      BCC_SRC_LABEL:   pos_sel = label_cmd;
      BCC_SRC_SINE:    pos_sel = sine_cmd;
      default:         pos_sel = pulse_cmd;
    endcase
  end

  always_comb begin
    pos_stage = pos_sel;
    if (inv_mask_r[`BCC_INV_POS_BIT]) begin
      pos_stage = -pos_stage;
    end
    // Reverse after the mask, so both together restore the sign
    if (position_reverse_in) begin
      pos_stage = -pos_stage;
    end
    pos_nxt = position_inhibit_in ? 32'sh00000000 : pos_stage;
    spd_nxt = inv_mask_r[`BCC_INV_SPD_BIT] ? -speed_cmd : speed_cmd;
    trq_nxt = inv_mask_r[`BCC_INV_TRQ_BIT] ? -torque_cmd : torque_cmd;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pos_r <= 32'sh00000000;
      spd_r <= 32'sh00000000;
      trq_r <= 32'sh00000000;
    end else begin
      pos_r <= pos_nxt;
      spd_r <= spd_nxt;
      trq_r <= trq_nxt;
    end
  end

  assign pos_cmd_out    = pos_r;
  assign speed_cmd_out  = spd_r;
  assign torque_cmd_out = trq_r;

endmodule

// ===== tb/bcc_assertions.sv
`timescale 1ns/1ps
`include "bcc_params.svh"
module bcc_assertions
  import bcc_pkg::*;
#(
  parameter logic [15:0] OV_FAULT_HI_V = 16'd760
) (
  // Clock and reset
  input wire logic              clock,
  input wire logic              arst_n,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pslverr,
  // Sensing and commands
  input wire logic [15:0]       bus_volt,
  input wire logic              position_inhibit_in,
  input wire bcc_pkg::bcc_cmd_t speed_cmd,
  input wire bcc_pkg::bcc_cmd_t torque_cmd,
  input wire bcc_pkg::bcc_cmd_t pos_cmd_out,
  input wire bcc_pkg::bcc_cmd_t speed_cmd_out,
  input wire bcc_pkg::bcc_cmd_t torque_cmd_out,
  // Power stage
  input wire logic              brake_on,
  input wire logic              ov_fault
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////
  chk_ov_sets: assert property (bus_volt > OV_FAULT_HI_V |=> ov_fault)
    else $error("overvoltage flag missing");
  chk_ov_sticky: assert property (ov_fault && !(psel && penable && pwrite
    && paddr == `BCC_OFF_STATUS && pwdata[1]) |=> ov_fault)
    else $error("overvoltage flag dropped without clear");
  chk_brake_cause: assert property (brake_on |-> $past(bus_volt) > 16'd380)
    else $error("brake on with bus at or below limit");
  chk_brake_low: assert property (bus_volt <= 16'd380 |=> !brake_on)
    else $error("brake not released");
  chk_inhibit_zero: assert property (position_inhibit_in |=> pos_cmd_out == '0)
    else $error("inhibited position command passed");
  chk_speed_path: assert property ($past(arst_n) |-> speed_cmd_out == $past(speed_cmd)
    || speed_cmd_out == -$past(speed_cmd))
    else $error("speed output not derived from speed input");
  chk_torque_path: assert property ($past(arst_n) |->
    torque_cmd_out == $past(torque_cmd) || torque_cmd_out == -$past(torque_cmd))
    else $error("torque output not derived from torque input");
  chk_err_phase: assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
  chk_err_decode: assert property (psel && penable |->
    pslverr == (paddr > `BCC_OFF_CONTROL || paddr[1:0] != 2'b00))
    else $error("error response does not match address decode");
  ////////////////////////////////////////
  cover property (brake_on);
  cover property ($rose(ov_fault));
  cover property (pslverr);
endmodule

// ===== tb/bcc_power_stage.sv
`timescale 1ns/1ps
module bcc_power_stage
  import bcc_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Requests from the bench
  input  wire logic [15:0] volt_req,
  input  wire logic        decel_req,
  input  wire logic        regen_req,
  // Toward the drive logic
  output logic [15:0]      bus_volt,
  output logic             decelerating,
  output logic             regen_active,
  output bcc_pkg::bcc_cmd_t plan_cmd,
  output bcc_pkg::bcc_cmd_t enc2_cmd,
  output bcc_pkg::bcc_cmd_t label_cmd,
  output bcc_pkg::bcc_cmd_t sine_cmd,
  output bcc_pkg::bcc_cmd_t speed_cmd,
  output bcc_pkg::bcc_cmd_t torque_cmd
);
  logic [15:0] volt_r;
  logic [15:0] volt_nxt;
  // Sensor lags the request by one sample
  always_comb begin
    volt_nxt = volt_req;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      volt_r <= 16'h0000;
    end else begin
      volt_r <= volt_nxt;
    end
  end
  assign bus_volt     = volt_r;
  assign decelerating = decel_req;
  assign regen_active = regen_req;
  // Distinct per source so a wrong select shows; sine sits on the negation corner
  assign plan_cmd   = 32'h0000_1A2B;
  assign enc2_cmd   = 32'hFFFF_F000;
  assign label_cmd  = 32'h0003_0405;
  assign sine_cmd   = 32'h8000_0000;
  assign speed_cmd  = 32'h0007_0C00;
  assign torque_cmd = 32'hFFFF_FFF9;
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`include "bcc_params.svh"
module tb_top;
  import bcc_pkg::*;
  logic        clock, arst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] volt_req, bus_volt;
  logic        decel_req, regen_req, decelerating, regen_active;
  logic        position_inhibit_in, position_reverse_in, position_source_switch_in;
  bcc_cmd_t    plan_cmd, enc2_cmd, label_cmd, sine_cmd, speed_cmd, torque_cmd;
  bcc_cmd_t    pos_cmd_out, speed_cmd_out, torque_cmd_out;
  logic        brake_on, ov_fault, resistor_overheat, brk_exp;
  int          fail_count = 0, check_count = 0, cyc = 0;
  logic [15:0] rstv [6] = '{16'h0002, 16'h0000, 16'h0000, 16'h0032, 16'h0000, 16'h0000};
  logic [15:0] badv [6] = '{16'h0004, 16'h0000, 16'h8000, 16'h0065, 16'h0008, 16'h0007};
  logic [15:0] maxv [6] = '{16'h0003, 16'hFFFF, 16'h7FFF, 16'h0064, 16'h0007, 16'h0006};
  bcc_top #(.TICK_CYC(4)) DUT (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .bus_volt, .decelerating, .regen_active, .position_inhibit_in,
    .position_reverse_in, .position_source_switch_in, .plan_cmd, .enc2_cmd, .label_cmd,
    .sine_cmd, .speed_cmd, .torque_cmd, .pos_cmd_out, .speed_cmd_out, .torque_cmd_out,
    .brake_on, .ov_fault, .resistor_overheat);
  bcc_power_stage u_stage (.clock, .arst_n, .volt_req, .decel_req, .regen_req, .bus_volt,
    .decelerating, .regen_active, .plan_cmd, .enc2_cmd, .label_cmd, .sine_cmd, .speed_cmd,
    .torque_cmd);
  ////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    cmp(rdat, exp);
  endtask
  task automatic settle();
    repeat (3) @(posedge clock);
  endtask
  task automatic volt(input logic [15:0] v);
    volt_req <= v;
    settle();
  endtask
  function automatic bcc_cmd_t pos_exp(input int s, input logic [2:0] mk, input logic [2:0] c);
    bcc_cmd_t b;
    case (s)
      1, 4: b = plan_cmd;
      2: b = c[2] ? plan_cmd : '0;
      3: b = enc2_cmd;
      5: b = label_cmd;
      6: b = sine_cmd;
      default: b = '0;
    endcase
    if (mk[0] ^ c[0]) b = -b;
    return c[1] ? '0 : b;
  endfunction
  task automatic summarize();
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Cut a hang well past the expected run length
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    volt_req = 16'h0;
    decel_req = 1'b0;
    regen_req = 1'b0;
    position_inhibit_in = 1'b0;
    position_reverse_in = 1'b0;
    position_source_switch_in = 1'b0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i), {16'h0, rstv[i]});
    end
    // Illegal values must leave the register alone; upper half never sticks
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'(4 * i), {16'hABCD, badv[i]});
      rd(8'(4 * i), {16'h0, rstv[i]});
      apb(1'b1, 8'(4 * i), {16'hABCD, maxv[i]});
      rd(8'(4 * i), {16'h0, maxv[i]});
    end
    rd(8'h20, 32'h0);
    cmp(rerr, 1'b1);
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, `BCC_OFF_POLICY, 32'(p));
      for (int m = 0; m < 8; m++) begin
        decel_req <= m[0];
        regen_req <= m[1];
        volt(m[2] ? 16'd381 : 16'd380);
        brk_exp = m[2] && (p == 2 || (p == 1 && m[0]) || (p == 3 && m[1]));
        cmp(brake_on, brk_exp);
      end
    end
    apb(1'b1, `BCC_OFF_CONTROL, 32'h1);
    apb(1'b1, `BCC_OFF_POLICY, 32'h2);
    volt(16'd680);
    cmp(brake_on, 1'b0);
    volt(16'd681);
    cmp(brake_on, 1'b1);
    rd(`BCC_OFF_CONTROL, 32'h1);
    apb(1'b0, `BCC_OFF_STATUS, 32'h0);
    cmp(rdat[15:0], 16'h0009);
    cmp(ov_fault, 1'b0);
    volt(16'd761);
    cmp(ov_fault, 1'b1);
    volt(16'd300);
    cmp(ov_fault, 1'b1);
    apb(1'b1, `BCC_OFF_STATUS, 32'h2);
    settle();
    cmp(ov_fault, 1'b0);
    apb(1'b1, `BCC_OFF_CONTROL, 32'h0);
    volt(16'd420);
    cmp(ov_fault, 1'b0);
    volt(16'd421);
    cmp(ov_fault, 1'b1);
    volt(16'd300);
    apb(1'b1, `BCC_OFF_STATUS, 32'h2);
    for (int s = 0; s < 7; s++) begin
      for (int k = 0; k < 8; k++) begin
        apb(1'b1, `BCC_OFF_POS_SRC, 32'(s));
        apb(1'b1, `BCC_OFF_INV_MASK, 32'(k));
        for (int c = 0; c < 8; c++) begin
          position_reverse_in <= c[0];
          position_inhibit_in <= c[1];
          position_source_switch_in <= c[2];
          settle();
          cmp(pos_cmd_out, pos_exp(s, 3'(k), 3'(c)));
          cmp(speed_cmd_out, k[1] ? -speed_cmd : speed_cmd);
          cmp(torque_cmd_out, k[2] ? -torque_cmd : torque_cmd);
        end
      end
    end
    // Full power and full decay already loaded by the register pass
    volt(16'd381);
    repeat (160) @(posedge clock);
    cmp(resistor_overheat, 1'b1);
    volt(16'd300);
    repeat (8) @(posedge clock);
    cmp(resistor_overheat, 1'b0);
    repeat (4 * 9880) @(posedge clock);
    apb(1'b0, `BCC_OFF_STATUS, 32'h0);
    cmp(rdat[15:0], 16'h0000);
    cmp(rdat[31:16] != 16'h0000, 1'b1);
    repeat (4 * 140) @(posedge clock);
    rd(`BCC_OFF_STATUS, 32'h0);
    summarize();
  end
endmodule
bind bcc_top bcc_assertions #(.OV_FAULT_HI_V(OV_FAULT_HI_V)) u_chk (.clock, .arst_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pslverr, .bus_volt, .position_inhibit_in, .speed_cmd,
  .torque_cmd, .pos_cmd_out, .speed_cmd_out, .torque_cmd_out, .brake_on, .ov_fault);
